/* File: src/ftr_pin_sync.sv */
// Purpose : Three-stage synchroniser with agreement filter for bus pins
// Assumes : Inputs are asynchronous to i_clk
// Notes   : Output changes only when stages two and three agree

`timescale 1ns/1ns
`default_nettype none

module ftr_pin_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         i_clk,      // Device clock
  input  wire logic         i_reset_n,  // Async reset, active low
  input  wire logic         i_ce,       // Clock enable
  input  wire logic [W-1:0] i_pin,      // Raw pin levels
  output logic      [W-1:0] o_level     // Filtered level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } ftr_sync_t;

  ftr_sync_t st_r;
  ftr_sync_t st_nxt;

  // ----------------------------------------------------------------
  // Next state: shift, accept bits where stages agree
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = i_pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int b = 0; b < W; b++) begin
      if (st_r.s2[b] == st_r.s3[b]) begin
        st_nxt.lvl[b] = st_r.s3[b];
      end
    end
  end

  // Registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= '{s1: RST, s2: RST, s3: RST, lvl: RST};
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.lvl;

endmodule : ftr_pin_sync

`default_nettype wire

/* File: src/ftr_pkg.sv */
// Purpose : Shared constants and types for the FIFO trigger / ready register block
// Assumes : Two channels (A = index 0, B = index 1), 8-bit host data bus
// Notes   : Every offset, field position and reset value lives here

package ftr_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_CH   = 2;
  localparam int ADDR_W   = 3;
  localparam int DATA_W   = 8;
  localparam int LVL_W    = 7;          // FIFO counts 0..64
  localparam int DLY_W    = 3;
  localparam int CTL_W    = 4;
  localparam int BUS_W    = ADDR_W + DATA_W;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_ALT_FUNC  = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_FIFO_RDY  = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_TRIG_LVL  = 3'h7;
  localparam logic [2:0]        LCR_ALT_KEY    = 3'h4;  // line control bits 7:5

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] TRIG_LVL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ALT_FUNC_RESET = 8'h00;
  localparam logic [CTL_W-1:0]  CTL_IDLE       = 4'hF;  // all strobes inactive
  localparam logic [BUS_W-1:0]  BUS_IDLE       = 11'h000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TL_TX_LSB    = 0;
  localparam int TL_RX_LSB    = 4;
  localparam int TL_NIB_W     = 4;
  localparam int AF_CONCURRENT_WRITE_ENABLE      = 0;
  localparam int AF_IR        = 1;
  localparam int AF_HDX       = 2;
  localparam int AF_DLY_LSB   = 5;
  localparam int RDY_TX_A     = 0;
  localparam int RDY_TX_B     = 1;
  localparam int RDY_RX_A     = 4;
  localparam int RDY_RX_B     = 5;
  localparam logic [DATA_W-1:0] RDY_USED_MASK = 8'h33;

  // Synchronised control vector bit order
  localparam int CTL_CSA = 3;
  localparam int CTL_CSB = 2;
  localparam int CTL_WR  = 1;
  localparam int CTL_RD  = 0;

  // ----------------------------------------------------------------
  // Bus driver enable sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FTR_DRV_IDLE = 2'b00,
    FTR_DRV_SEND = 2'b01,
    FTR_DRV_HOLD = 2'b10
  } ftr_drv_t;

endpackage : ftr_pkg

/* File: src/ftr_regs.sv */
// Purpose : FIFO trigger level, FIFO ready and alternate function registers
// Assumes : Host strobes are async pins; UART channel status is on i_clk
// Notes   : Returns o_claim high when this block owns the read data
//
// Overview of operation
// - Trigger level low nibble sets transmit level in free spaces, 4 to 60.
// - Trigger level high nibble sets receive level in characters, 4 to 60.
// - Trigger level writes land only with enhanced bit 4 and modem bit 6 set.
// - A zero nibble falls back to the FIFO control selectable level.
// - Each nibble holds level over four; hardware multiplies it by four.
// - Ready bits 0,1 set when channel A/B transmit has enough free spaces.
// - Ready bits 4,5 set when channel A/B receive exceeds level or timed out.
// - Ready status is live, never latched, for both channels.
// - Ready bits use FIFO control level for zero nibble, else programmed one.
// - Ready register is read-only and reachable through either chip select.
// - Ready register sits at address 7 with modem bit 2 set, no loopback.
// - Alternate function register decodes at address 2 when line bits are 100.
// - Alternate bit 0 makes host writes land on every channel at once.
// - Per-channel bus driver enable stays active while transmit data pends.
// - Alternate function provides infrared SIR mode for 2400 to 115.2 kbps.
// - Half-duplex bit: driver enable high with data, held until delay expires.

`timescale 1ns/1ns
`default_nettype none

module ftr_regs
  import ftr_pkg::*;
(
  input  wire logic                         i_clk,           // Device clock, 10 MHz
  input  wire logic                         i_reset_n,       // Async reset, active low
  input  wire logic                         i_ce,            // Clock enable
  input  wire logic                         i_cs_a_n,        // Channel A select pin
  input  wire logic                         i_cs_b_n,        // Channel B select pin
  input  wire logic                         i_wr_n,          // Write strobe pin
  input  wire logic                         i_rd_n,          // Read strobe pin
  input  wire logic [ADDR_W-1:0]            i_addr,          // Register address pins
  input  wire logic [DATA_W-1:0]            i_data,          // Data bus input
  output logic      [DATA_W-1:0]            o_data,          // Data bus output
  output logic                              o_data_oe_n,     // Data bus enable, low drives
  output logic                              o_claim,         // This block answers the read
  input  wire logic [NUM_CH-1:0]            i_enh_enable,    // Enhanced feature bit 4
  input  wire logic [NUM_CH-1:0]            i_mcr_tlr_sel,   // Modem control bit 6
  input  wire logic [NUM_CH-1:0]            i_mcr_rdy_en,    // Modem control bit 2
  input  wire logic [NUM_CH-1:0]            i_loopback,      // Loopback active
  input  wire logic [NUM_CH-1:0][2:0]       i_lcr_top,       // Line control bits 7:5
  input  wire logic [NUM_CH-1:0][LVL_W-1:0] i_fcr_tx_level,  // Selectable TX level
  input  wire logic [NUM_CH-1:0][LVL_W-1:0] i_fcr_rx_level,  // Selectable RX level
  input  wire logic [NUM_CH-1:0][LVL_W-1:0] i_tx_free,       // TX FIFO free spaces
  input  wire logic [NUM_CH-1:0][LVL_W-1:0] i_rx_count,      // RX FIFO characters
  input  wire logic [NUM_CH-1:0]            i_rx_timeout,    // RX timeout flag
  input  wire logic [NUM_CH-1:0]            i_tx_busy,       // Holding or shift reg has data
  input  wire logic [NUM_CH-1:0]            i_bit_tick,      // One pulse per bit time
  output logic      [NUM_CH-1:0][LVL_W-1:0] o_tx_level,      // Effective TX trigger level
  output logic      [NUM_CH-1:0][LVL_W-1:0] o_rx_level,      // Effective RX trigger level
  output logic      [DATA_W-1:0]            o_fifo_ready,    // Live ready status
  output logic      [NUM_CH-1:0]            o_ir_mode,       // Infrared SIR enable
  output logic      [NUM_CH-1:0]            o_half_duplex,   // Half-duplex bus mode
  output logic      [NUM_CH-1:0]            o_bus_drv_en     // Bus driver enable out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Nibble to entries; zero selects the fallback level
  function automatic logic [LVL_W-1:0] eff_level(input logic [TL_NIB_W-1:0] nib,
                                                 input logic [LVL_W-1:0]    fallback);
    if (nib == '0) begin
      eff_level = fallback;
    end else begin
      eff_level = {1'b0, nib, 2'b00};
    end
  endfunction : eff_level

  typedef struct packed {
    logic [NUM_CH-1:0][DATA_W-1:0] fifo_trigger_levels;
    logic [NUM_CH-1:0][DATA_W-1:0] alternate_function;
    logic [CTL_W-1:0]              ctl_prev;
    logic [DATA_W-1:0]             rd_data;
    logic                          claim;
    logic [DATA_W-1:0]             frdy;
    logic [NUM_CH-1:0][LVL_W-1:0]  tx_lvl;
    logic [NUM_CH-1:0][LVL_W-1:0]  rx_lvl;
    ftr_drv_t [NUM_CH-1:0]         dst;
    logic [NUM_CH-1:0][DLY_W-1:0]  dcnt;
    logic [NUM_CH-1:0]             drv;
  } ftr_state_t;

  ftr_state_t st_r;
  ftr_state_t st_nxt;

  logic [CTL_W-1:0] ctl;
  logic [BUS_W-1:0] bus;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr_ev;
  logic              rd_act;
  logic              sel_b;
  logic [NUM_CH-1:0] tgt;
  logic [NUM_CH-1:0] tlr_ok;
  logic [NUM_CH-1:0] afr_ok;
  logic              concurrent_write_enable;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  ftr_pin_sync #(.W(CTL_W), .RST(CTL_IDLE)) u_ctl_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_ce      (i_ce),
    .i_pin     ({i_cs_a_n, i_cs_b_n, i_wr_n, i_rd_n}),
    .o_level   (ctl)
  );

  ftr_pin_sync #(.W(BUS_W), .RST(BUS_IDLE)) u_bus_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_ce      (i_ce),
    .i_pin     ({i_addr, i_data}),
    .o_level   (bus)
  );

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  // Write taken at end of strobe, with selects from while it was low
  assign addr   = bus[BUS_W-1:DATA_W];
  assign wdata  = bus[DATA_W-1:0];
  assign wr_ev  = !st_r.ctl_prev[CTL_WR] && ctl[CTL_WR];
  assign rd_act = !ctl[CTL_RD] && (!ctl[CTL_CSA] || !ctl[CTL_CSB]);
  assign sel_b  = ctl[CTL_CSA];
  assign concurrent_write_enable   = st_r.alternate_function[0][AF_CONCURRENT_WRITE_ENABLE] || st_r.alternate_function[1][AF_CONCURRENT_WRITE_ENABLE];
  assign tgt    = concurrent_write_enable ? {NUM_CH{1'b1}}
                       : {!st_r.ctl_prev[CTL_CSB], !st_r.ctl_prev[CTL_CSA]};

  // Per-channel map selectors
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      tlr_ok[c] = i_enh_enable[c] && i_mcr_tlr_sel[c];
      afr_ok[c] = (i_lcr_top[c] == LCR_ALT_KEY);
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.ctl_prev = ctl;

    // Register writes; the ready register has no write path
    for (int c = 0; c < NUM_CH; c++) begin
      if (wr_ev && tgt[c]) begin
        if (addr == ADDR_TRIG_LVL && tlr_ok[c]) begin
          st_nxt.fifo_trigger_levels[c] = wdata;
        end
        if (addr == ADDR_ALT_FUNC && afr_ok[c]) begin
          st_nxt.alternate_function[c] = wdata;
        end
      end
    end

    // Effective trigger levels
    for (int c = 0; c < NUM_CH; c++) begin
      st_nxt.tx_lvl[c] = eff_level(st_r.fifo_trigger_levels[c][TL_TX_LSB +: TL_NIB_W],
                                   i_fcr_tx_level[c]);
      st_nxt.rx_lvl[c] = eff_level(st_r.fifo_trigger_levels[c][TL_RX_LSB +: TL_NIB_W],
                                   i_fcr_rx_level[c]);
    end

    // Live ready status, refreshed every cycle
    st_nxt.frdy           = '0;
    st_nxt.frdy[RDY_TX_A] = (i_tx_free[0] >= st_nxt.tx_lvl[0]);
    st_nxt.frdy[RDY_TX_B] = (i_tx_free[1] >= st_nxt.tx_lvl[1]);
    st_nxt.frdy[RDY_RX_A] = (i_rx_count[0] > st_nxt.rx_lvl[0]) || i_rx_timeout[0];
    st_nxt.frdy[RDY_RX_B] = (i_rx_count[1] > st_nxt.rx_lvl[1]) || i_rx_timeout[1];

    // Read mux; trigger level access mode outranks the ready view
    st_nxt.claim   = 1'b0;
    st_nxt.rd_data = '0;
    if (rd_act) begin
      if (addr == ADDR_TRIG_LVL && tlr_ok[sel_b]) begin
        st_nxt.claim   = 1'b1;
        st_nxt.rd_data = st_r.fifo_trigger_levels[sel_b];
      end else if (addr == ADDR_FIFO_RDY && i_mcr_rdy_en[sel_b]
                   && !i_loopback[sel_b]) begin
        st_nxt.claim   = 1'b1;
        st_nxt.rd_data = st_nxt.frdy & RDY_USED_MASK;
      end else if (addr == ADDR_ALT_FUNC && afr_ok[sel_b]) begin
        st_nxt.claim   = 1'b1;
        st_nxt.rd_data = st_r.alternate_function[sel_b];
      end
    end

    // Bus driver enable sequencer per channel
    for (int c = 0; c < NUM_CH; c++) begin
      case (st_r.dst[c])
        FTR_DRV_IDLE: begin
          if (st_r.alternate_function[c][AF_HDX] && i_tx_busy[c]) begin
            st_nxt.dst[c] = FTR_DRV_SEND;
          end
        end
        FTR_DRV_SEND: begin
          if (!st_r.alternate_function[c][AF_HDX]) begin
            st_nxt.dst[c] = FTR_DRV_IDLE;
          end else if (!i_tx_busy[c]) begin
            st_nxt.dst[c]  = FTR_DRV_HOLD;
            st_nxt.dcnt[c] = '0;
          end
        end
        FTR_DRV_HOLD: begin
          if (!st_r.alternate_function[c][AF_HDX]) begin
            st_nxt.dst[c] = FTR_DRV_IDLE;
          end else if (i_tx_busy[c]) begin
            st_nxt.dst[c] = FTR_DRV_SEND;
          end else if (st_r.dcnt[c] == st_r.alternate_function[c][AF_DLY_LSB +: DLY_W]) begin
            st_nxt.dst[c] = FTR_DRV_IDLE;
          end else if (i_bit_tick[c]) begin
            st_nxt.dcnt[c] = st_r.dcnt[c] + 3'h1;
          end
        end
        default: begin
          st_nxt.dst[c] = FTR_DRV_IDLE;
        end
      endcase
      st_nxt.drv[c] = (st_nxt.dst[c] != FTR_DRV_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r          <= '0;
      st_r.fifo_trigger_levels      <= {NUM_CH{TRIG_LVL_RESET}};
      st_r.alternate_function      <= {NUM_CH{ALT_FUNC_RESET}};
      st_r.ctl_prev <= CTL_IDLE;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_data       = st_r.rd_data;
  assign o_claim      = st_r.claim;
  assign o_data_oe_n  = !(st_r.claim && rd_act);
  assign o_tx_level   = st_r.tx_lvl;
  assign o_rx_level   = st_r.rx_lvl;
  assign o_fifo_ready = st_r.frdy;
  assign o_bus_drv_en = st_r.drv;

  // Mode bits straight from the alternate function registers
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      o_ir_mode[c]     = st_r.alternate_function[c][AF_IR];
      o_half_duplex[c] = st_r.alternate_function[c][AF_HDX];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_tlr_wr_a;
    i_ce && wr_ev && tgt[0] && addr == ADDR_TRIG_LVL;
  endsequence

  sequence s_busy_a;
    i_ce && st_r.alternate_function[0][AF_HDX] && i_tx_busy[0];
  endsequence

  sequence s_drained_a;
    i_ce && st_r.dst[0] == FTR_DRV_HOLD && !i_tx_busy[0]
      && st_r.alternate_function[0][AF_HDX]
      && st_r.dcnt[0] == st_r.alternate_function[0][AF_DLY_LSB +: DLY_W];
  endsequence

  a_tlr_gate_hold: assert property (s_tlr_wr_a and !tlr_ok[0] |=> $stable(st_r.fifo_trigger_levels[0]))
    else $error("trigger level changed while writes locked");

  a_tlr_write_take: assert property (s_tlr_wr_a and tlr_ok[0] |=> st_r.fifo_trigger_levels[0] == $past(wdata))
    else $error("trigger level write lost");

  a_level_fallback: assert property (i_ce && st_r.fifo_trigger_levels[0][TL_TX_LSB +: TL_NIB_W] == '0
      |=> o_tx_level[0] == $past(i_fcr_tx_level[0]))
    else $error("zero nibble did not select fallback level");

  a_level_scale: assert property (i_ce && st_r.fifo_trigger_levels[1][TL_RX_LSB +: TL_NIB_W] != '0
      |=> o_rx_level[1] == {1'b0, $past(st_r.fifo_trigger_levels[1][TL_RX_LSB +: TL_NIB_W]), 2'b00})
    else $error("receive level not four times nibble");

  a_tx_ready_live: assert property (i_ce |=> o_fifo_ready[RDY_TX_A]
      == ($past(i_tx_free[0]) >= o_tx_level[0]))
    else $error("channel A transmit ready wrong");

  a_rx_ready_live: assert property (i_ce |=> o_fifo_ready[RDY_RX_B]
      == (($past(i_rx_count[1]) > o_rx_level[1]) || $past(i_rx_timeout[1])))
    else $error("channel B receive ready wrong");

  a_tx_ready_b: assert property (i_ce |=> o_fifo_ready[RDY_TX_B]
      == ($past(i_tx_free[1]) >= o_tx_level[1]))
    else $error("channel B transmit ready wrong");

  a_rx_ready_a: assert property (i_ce |=> o_fifo_ready[RDY_RX_A]
      == (($past(i_rx_count[0]) > o_rx_level[0]) || $past(i_rx_timeout[0])))
    else $error("channel A receive ready wrong");

  a_rdy_no_write: assert property (i_ce && wr_ev && tgt[1] && addr == ADDR_FIFO_RDY
      && !tlr_ok[1] |=> $stable(st_r.fifo_trigger_levels[1]) && $stable(st_r.alternate_function[1]))
    else $error("write at ready address changed a register");

  a_claim_release: assert property (i_ce && !rd_act |=> !o_claim && o_data == '0)
    else $error("read answer without an active read");

  a_unused_zero: assert property ((o_fifo_ready & ~RDY_USED_MASK) == '0)
    else $error("unused ready bits set");

  a_rdy_read_map: assert property (i_ce && rd_act && addr == ADDR_FIFO_RDY && !tlr_ok[sel_b]
      && i_mcr_rdy_en[sel_b] && !i_loopback[sel_b] |=> o_claim && o_data == o_fifo_ready)
    else $error("ready register not returned");

  a_afr_decode: assert property (i_ce && wr_ev && tgt[1] && addr == ADDR_ALT_FUNC
      && !afr_ok[1] |=> $stable(st_r.alternate_function[1]))
    else $error("alternate function written outside key pattern");

  a_concurrent_write_enable_write: assert property (i_ce && wr_ev && concurrent_write_enable && addr == ADDR_ALT_FUNC
      && afr_ok == 2'h3 |=> st_r.alternate_function[0] == st_r.alternate_function[1])
    else $error("concurrent write missed a channel");

  a_drv_follow: assert property (s_busy_a |=> o_bus_drv_en[0])
    else $error("driver enable low with data pending");

  a_drv_release: assert property (s_drained_a |=> !o_bus_drv_en[0])
    else $error("driver enable held past delay");

  a_ir_mode: assert property (o_ir_mode[0] == st_r.alternate_function[0][AF_IR])
    else $error("infrared mode not following register");

endmodule : ftr_regs

`default_nettype wire

/* File: tb/ftr_host.sv */
// Purpose : Host processor model driving the register pins
// Assumes : Strobes active low, one access at a time
// Notes   : Released data lines show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module ftr_host
  import ftr_pkg::*;
(
  input  wire logic              i_clk,    // Device clock
  input  wire logic [DATA_W-1:0] i_rdata,  // Read data from block
  input  wire logic              i_claim,  // Block answers read
  input  wire logic              i_oe_n,   // Data bus enable from block
  output logic                   o_cs_a_n, // Channel A select
  output logic                   o_cs_b_n, // Channel B select
  output logic                   o_wr_n,   // Write strobe
  output logic                   o_rd_n,   // Read strobe
  output logic      [ADDR_W-1:0] o_addr,   // Address pins
  output logic      [DATA_W-1:0] o_data    // Data bus
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  initial begin
    {o_cs_a_n, o_cs_b_n, o_wr_n, o_rd_n} = CTL_IDLE;
    o_addr = '0;
    o_data = '0;
  end
  // Step to just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  // Write: strobe low six clocks, selects held two past its rise
  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    o_addr = a;
    o_data = d;
    o_cs_a_n = ch;
    o_cs_b_n = !ch;
    o_wr_n = 1'b0;
    tick(6);
    o_wr_n = 1'b1;
    tick(2);
    {o_cs_a_n, o_cs_b_n} = 2'h3;
    o_data = ~d;  // Released bus, no stale value
    tick(8);
  endtask : wr
  // Read: answer taken at the edge before the strobe is lifted
  task automatic rd(input logic ch, input logic [2:0] a, output logic [7:0] d,
                    output logic c, output logic e);
    o_addr = a;
    o_cs_a_n = ch;
    o_cs_b_n = !ch;
    o_rd_n = 1'b0;
    tick(7);
    d = i_rdata;
    c = i_claim;
    e = i_oe_n;
    o_rd_n = 1'b1;
    tick(1);
    {o_cs_a_n, o_cs_b_n} = 2'h3;
    tick(8);
  endtask : rd
endmodule : ftr_host
`default_nettype wire

/* File: tb/tb.sv */
// Purpose : Self-checking bench for the trigger / ready register block
// Assumes : Host model drives the pins; channel status driven here
// Notes   : Channel A is index 0, B is index 1
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ftr_pkg::*;
  logic                         clk = 1'b0;
  logic                         rst_n = 1'b0;
  logic [NUM_CH-1:0]            enh, tsel, rdy_en, lpb, tmo, busy, btick;
  logic [NUM_CH-1:0][2:0]       line_control_reg;
  logic [NUM_CH-1:0][LVL_W-1:0] fcr_tx, fcr_rx, tx_free, rx_cnt, tx_lvl, rx_lvl;
  logic                         cs_a_n, cs_b_n, wr_n, rd_n, oe_n, claim, c, e, ce;
  logic [ADDR_W-1:0]            addr;
  logic [DATA_W-1:0]            wdata, rdata, rdy, d;
  logic [NUM_CH-1:0]            ir, hdx, drv;
  int                           error_cnt = 0;
  int                           cmp_count = 0;
  // ----------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------
  always #50 clk = ~clk;
  ftr_regs dut (.i_clk(clk), .i_reset_n(rst_n), .i_ce(ce), .i_cs_a_n(cs_a_n),
    .i_cs_b_n(cs_b_n), .i_wr_n(wr_n), .i_rd_n(rd_n), .i_addr(addr), .i_data(wdata),
    .o_data(rdata), .o_data_oe_n(oe_n), .o_claim(claim), .i_enh_enable(enh),
    .i_mcr_tlr_sel(tsel), .i_mcr_rdy_en(rdy_en), .i_loopback(lpb), .i_lcr_top(line_control_reg),
    .i_fcr_tx_level(fcr_tx), .i_fcr_rx_level(fcr_rx), .i_tx_free(tx_free),
    .i_rx_count(rx_cnt), .i_rx_timeout(tmo), .i_tx_busy(busy), .i_bit_tick(btick),
    .o_tx_level(tx_lvl), .o_rx_level(rx_lvl), .o_fifo_ready(rdy), .o_ir_mode(ir),
    .o_half_duplex(hdx), .o_bus_drv_en(drv));
  ftr_host host (.i_clk(clk), .i_rdata(rdata), .i_claim(claim), .i_oe_n(oe_n), .o_cs_a_n(cs_a_n),
    .o_cs_b_n(cs_b_n), .o_wr_n(wr_n), .o_rd_n(rd_n), .o_addr(addr), .o_data(wdata));
  // ----------------------------------------------------------------
  // Checking and verdict
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic give_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // Zero nibbles fall back to the selectable levels
  task automatic t_fallback;
    chk("tx_lvl_a", 8'h08, {1'b0, tx_lvl[0]});
    chk("rx_lvl_b", 8'h20, {1'b0, rx_lvl[1]});
    ce = 1'b0;  // Frozen block must not pick up a new selectable level
    fcr_tx = {7'd16, 7'd24};
    host.tick(3);
    chk("tx_lvl_frozen", 8'h08, {1'b0, tx_lvl[0]});
    ce = 1'b1;
    host.tick(2);
    chk("tx_lvl_new_fcr", 8'h18, {1'b0, tx_lvl[0]});
    fcr_tx = {7'd16, 7'd8};
  endtask : t_fallback
  // Refused then accepted trigger level write on channel A
  task automatic t_trigger;
    host.wr(1'b0, 3'h7, 8'h3F);
    chk("tx_lvl_refused", 8'h08, {1'b0, tx_lvl[0]});
    tsel = 2'h1;
    enh = 2'h2;
    host.wr(1'b0, 3'h7, 8'h3F);
    chk("tx_lvl_no_enh", 8'h08, {1'b0, tx_lvl[0]});
    enh = 2'h3;
    host.wr(1'b0, 3'h7, 8'h3F);  // Level over four in each nibble
    chk("tx_lvl_a", 8'h3C, {1'b0, tx_lvl[0]});
    chk("rx_lvl_a", 8'h0C, {1'b0, rx_lvl[0]});
    chk("tx_lvl_b", 8'h10, {1'b0, tx_lvl[1]});
    host.rd(1'b0, 3'h7, d, c, e);
    chk("tlr_read_a", 8'h3F, d);
    tsel = 2'h0;
  endtask : t_trigger
  // Live ready bits at the level boundaries, then read over the pins
  task automatic t_ready;
    tx_free = {7'd16, 7'd60};
    rx_cnt  = {7'd33, 7'd13};
    host.tick(3);
    chk("ready_set", 8'h33, rdy);
    tx_free = {7'd15, 7'd59};
    rx_cnt  = {7'd32, 7'd12};
    host.tick(3);
    chk("ready_clear", 8'h00, rdy);
    tmo = 2'h2;
    host.tick(3);
    chk("ready_timeout", 8'h20, rdy);
    host.wr(1'b1, 3'h7, 8'hFF);
    host.rd(1'b1, 3'h7, d, c, e);
    chk("ready_read_b", 8'h20, d);
    chk("ready_claim", 8'h01, {7'h00, c});
    chk("ready_oe", 8'h00, {7'h00, e});
    lpb = 2'h3;
    host.rd(1'b0, 3'h7, d, c, e);
    chk("ready_loopback", 8'h00, {7'h00, c});
    chk("data_loopback", 8'h00, d);
    chk("oe_loopback", 8'h01, {7'h00, e});
    lpb = 2'h0;
    rdy_en = 2'h1;
    host.rd(1'b1, 3'h7, d, c, e);
    chk("ready_disabled", 8'h00, {7'h00, c});
    rdy_en = 2'h3;
  endtask : t_ready
  // Alternate register key, then concurrent write to both channels
  task automatic t_alt;
    host.wr(1'b0, 3'h2, 8'h06);
    chk("ir_nokey", 8'h00, {6'h00, ir});
    line_control_reg = {3'h4, 3'h4};  // Indirect access opened before broadcast
    host.wr(1'b0, 3'h2, 8'h06);
    chk("ir_key", 8'h01, {6'h00, ir});
    host.wr(1'b0, 3'h2, 8'h01);
    host.wr(1'b0, 3'h2, 8'h45);
    chk("hdx_concurrent_write_enable", 8'h03, {6'h00, hdx});
    host.rd(1'b1, 3'h2, d, c, e);
    chk("afr_read_b", 8'h45, d);
  endtask : t_alt
  // Driver enable follows pending data, then holds two bit times
  task automatic t_drv;
    busy = 2'h1;
    host.tick(3);
    chk("drv_busy", 8'h01, {6'h00, drv});
    busy = 2'h0;
    host.tick(3);
    chk("drv_hold", 8'h01, {6'h00, drv});
    repeat (2) begin
      btick = 2'h1;
      host.tick(1);
      btick = 2'h0;
      host.tick(1);
    end
    host.tick(2);
    chk("drv_done", 8'h00, {6'h00, drv});
  endtask : t_drv
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {enh, tsel, rdy_en, lpb, tmo, busy, btick} = '0;
    line_control_reg = '0;
    ce = 1'b1;
    fcr_tx = {7'd16, 7'd8};
    fcr_rx = {7'd32, 7'd4};
    tx_free = '0;
    rx_cnt = '0;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    host.tick(4);
    enh = 2'h3;
    rdy_en = 2'h3;
    t_fallback();
    t_trigger();
    t_ready();
    t_alt();
    t_drv();
    give_verdict();
  end
  initial begin
    #3000000;
    error_cnt++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire
